// ==== hdl/edoctl_host.sv ====
// Host controller driving an asynchronous EXTENDED_DATA_OUT_PAGE DRAM through its strobes
`timescale 1ns/1ps
`default_nettype none

// Function
// [R1] Wait power-up pause, then eight refresh cycles before any access.
// [R2] Repeat eight wake-up refreshes whenever refresh period was exceeded.
// [R3] Refresh every row within the refresh period via distributed refresh.
// [R4] Early write: write strobe low before column strobe; outputs stay open.
// [R5] Read-modify-write: write strobe after row, column delays; outputs show data.
// [R6] Missing both write timings leaves output undefined; never issued here.
// [R7] Output enable high, write strobe after column strobe gives late write.
// [R8] Column strobe low at row fall keeps old data; pulse it high first.
// [R9] Write data sampled at later of column or write strobe fall.
// [R10] With output enable held low no late or read-modify writes.
// [R11] Hold output enable high past disable delay before driving write data.
// [R12] Output enable back low with column low re-drives read data.
// [R13] Column strobe rising before output enable low keeps pins open.
// [R14] Device releases data within off-delay after last strobe rises.
// [R15] Refresh: column low before row falls, held low afterwards.
// [R16] Row strobe low no longer than the single-cycle maximum.
// [R17] Long column-first refresh enters self refresh; long row high exits.
// [R18] Write strobe held high around row fall during refresh.
// [R19] Page reads keep data a short hold after next column fall.
// [R20] Page data follows column rise; page cycle has a minimum time.
// [R21] Read data valid after row, address and column access limits.
// [R22] Write pulse while column high tri-states device outputs.
// [R23] Self refresh entered by refresh cycle then long row strobe low.
// [R24] Minimum times round up, maximum times round down, to clock cycles.
module edoctl_host #(
    parameter int unsigned WAKE_CYC = edoctl_pkg::C_WAKE, // power-up pause
    parameter int unsigned RASS_CYC = edoctl_pkg::C_RASS, // self refresh hold
    parameter int unsigned RINT_CYC = edoctl_pkg::C_RINT  // refresh interval
) (
    input  wire logic                           clk,       // 40 MHz clock
    input  wire logic                           rst_n,     // async reset
    input  wire logic                           req,       // access request
    input  wire edoctl_pkg::edoctl_op_t         req_op,    // access kind
    input  wire logic [2*edoctl_pkg::ADR_W-1:0] req_addr,  // row, column
    input  wire logic [edoctl_pkg::DQ_W-1:0]    req_wdata, // write data
    input  wire logic                           sleep,     // hold self refresh
    output logic                                ready,     // accepts req
    output logic                                rvalid,    // read data pulse
    output logic [edoctl_pkg::DQ_W-1:0]         rdata,     // read data
    output logic                                ras_n,     // row strobe
    output logic                                cas_n,     // column strobe
    output logic                                we_n,      // write strobe
    output logic                                oe_n,      // output enable
    output logic [edoctl_pkg::ADR_W-1:0]        addr,      // muxed address
    input  wire logic [edoctl_pkg::DQ_W-1:0]    dq_in,     // data pins in
    output logic [edoctl_pkg::DQ_W-1:0]         dq_out,    // data pins out
    output logic                                dq_oe_n    // low drives dq
);
    typedef enum logic [3:0] {
        S_WAKE, S_IDLE, S_PRE, S_RAS, S_CAS, S_ACC, S_WR, S_DRV, S_HOLD,
        S_CSR, S_CHR, S_SELF, S_RPS
    } edoctl_st_t;
    localparam int unsigned W = edoctl_pkg::CNT_W;

    ////////////////////////////////////////////////////////////////
    logic       r1_r, rst_sync_n;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r1_r       <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            r1_r       <= 1'b1;
            rst_sync_n <= r1_r;
        end
    end

    ////////////////////////////////////////////////////////////////
    edoctl_st_t st_r, st_nxt;
    logic [W-1:0] cnt_r, cnt_nxt, rcnt_r, rcnt_nxt, ras_cnt_r, ras_cnt_nxt;
    logic [3:0] wk_r, wk_nxt;
    logic       woken_r, woken_nxt, rdue_r, rdue_nxt;
    edoctl_pkg::edoctl_op_t op_r, op_nxt;
    logic [2*edoctl_pkg::ADR_W-1:0] a_r, a_nxt;
    logic [edoctl_pkg::DQ_W-1:0] wd_r, wd_nxt, rd_r, rd_nxt;
    logic ras_nxt, cas_nxt, we_nxt, oe_nxt, dqo_nxt, rv_nxt, rdy_nxt;
    logic [edoctl_pkg::ADR_W-1:0] ad_nxt;

    function automatic logic [W-1:0] c(input int unsigned v);
        return W'(v);
    endfunction

    always_comb begin
        st_nxt = st_r; cnt_nxt = cnt_r; wk_nxt = wk_r; woken_nxt = woken_r;
        op_nxt = op_r; a_nxt = a_r; wd_nxt = wd_r; rd_nxt = rd_r;
        ras_nxt = ras_n; cas_nxt = cas_n; we_nxt = we_n; oe_nxt = oe_n;
        dqo_nxt = dq_oe_n; ad_nxt = addr; rv_nxt = 1'b0; rdy_nxt = 1'b0;
        ras_cnt_nxt = ras_n ? '0 : ras_cnt_r + 1'b1;
        // Distributed refresh interval, sticky due flag [R3]
        rcnt_nxt = (rcnt_r == c(RINT_CYC) - 1'b1) ? '0 : rcnt_r + 1'b1;
        rdue_nxt = rdue_r | (rcnt_r == c(RINT_CYC) - 1'b1);
        // Missed refresh long past due: force re-wake [R2]
        if (rdue_r && rcnt_r == c(RINT_CYC) - 1'b1 && woken_r && st_r != S_SELF) begin
            woken_nxt = 1'b0;
            wk_nxt    = '0;
        end
        if (cnt_r != '0) cnt_nxt = cnt_r - 1'b1;
        case (st_r)
            S_WAKE: if (cnt_r == '0) begin // [R1]
                st_nxt = S_PRE; cnt_nxt = c(edoctl_pkg::C_RP);
            end
            S_IDLE: begin
                // Take only what ready announced; a refresh that fell due waits one access
                if (req && ready) begin
                    op_nxt = req_op; a_nxt = req_addr; wd_nxt = req_wdata;
                    st_nxt = S_PRE; cnt_nxt = c(edoctl_pkg::C_RP);
                end else if (!woken_r || rdue_r || sleep) begin
                    st_nxt = S_PRE; cnt_nxt = c(edoctl_pkg::C_RP);
                end else rdy_nxt = 1'b1;
            end
            S_PRE: begin
                // Row address settles two cycles (C_RP) ahead of the row strobe
                ad_nxt = a_r[2*edoctl_pkg::ADR_W-1:edoctl_pkg::ADR_W];
                if (cnt_r == '0) begin
                    if (!woken_r || rdue_r || sleep) begin
                        // Column first, write high well before row fall [R15] [R18]
                        cas_nxt = 1'b0; we_nxt = 1'b1;
                        st_nxt = S_CSR;
                        cnt_nxt = c(edoctl_pkg::C_CSR > edoctl_pkg::C_WRP ? edoctl_pkg::C_CSR : edoctl_pkg::C_WRP);
                    end else begin
                        ras_nxt = 1'b0; st_nxt = S_RAS; cnt_nxt = c(edoctl_pkg::C_RCD);
                        // Write strobe low before column fall: early write [R4]
                        we_nxt = (op_r != edoctl_pkg::EDOCTL_OP_WRITE);
                        oe_nxt = (op_r == edoctl_pkg::EDOCTL_OP_WRITE);
                    end
                end
            end
            S_RAS: begin
                // Column address a cycle before the column strobe, row held meanwhile
                ad_nxt = a_r[edoctl_pkg::ADR_W-1:0];
                if (cnt_r == '0) begin
                    // Column fall only from precharged state [R8]
                    cas_nxt = 1'b0;
                    dqo_nxt = (op_r != edoctl_pkg::EDOCTL_OP_WRITE); // data ready at column fall [R9]
                    st_nxt = S_ACC; cnt_nxt = c(edoctl_pkg::C_ACC);
                end
            end
            S_ACC: if (cnt_r == '0) begin
                if (op_r == edoctl_pkg::EDOCTL_OP_WRITE) begin
                    st_nxt = S_HOLD; cnt_nxt = c(edoctl_pkg::C_CP);
                end else begin
                    // Access limits met, capture [R21]
                    rd_nxt = dq_in;
                    if (op_r == edoctl_pkg::EDOCTL_OP_READ) begin
                        rv_nxt = 1'b1; st_nxt = S_HOLD; cnt_nxt = c(edoctl_pkg::C_CP);
                    end else begin
                        // Output enable high before driving [R11] [R10]
                        oe_nxt = 1'b1; st_nxt = S_WR; cnt_nxt = c(edoctl_pkg::C_OD);
                    end
                end
            end
            S_WR: if (cnt_r == '0) begin
                // Late write strobe, row delay long past [R5] [R7]
                dqo_nxt = 1'b0; we_nxt = 1'b0; rv_nxt = 1'b1;
                st_nxt = S_DRV; cnt_nxt = c(edoctl_pkg::C_RWD);
            end
            S_DRV: if (cnt_r == '0) begin
                st_nxt = S_HOLD; cnt_nxt = c(edoctl_pkg::C_CP);
            end
            S_HOLD: if (cnt_r == '0 && ras_cnt_r >= c(edoctl_pkg::C_RAS)) begin
                // Both strobes rise; we release dq too [R14] [R13]
                ras_nxt = 1'b1; cas_nxt = 1'b1; we_nxt = 1'b1; oe_nxt = 1'b1;
                dqo_nxt = 1'b1; st_nxt = S_IDLE; cnt_nxt = c(edoctl_pkg::C_RP);
            end
            S_CSR: if (cnt_r == '0) begin
                ras_nxt = 1'b0; st_nxt = S_CHR;
                cnt_nxt = c(edoctl_pkg::C_RAS);
            end
            S_CHR: if (cnt_r == '0) begin
                if (sleep && woken_r && !rdue_r) begin
                    st_nxt = S_SELF; cnt_nxt = c(RASS_CYC); // [R17] [R23]
                end else begin
                    ras_nxt = 1'b1; cas_nxt = 1'b1;
                    // A wrap in this very cycle keeps the flag set
                    rdue_nxt = (rcnt_r == c(RINT_CYC) - 1'b1);
                    if (!woken_r) begin
                        wk_nxt = wk_r + 1'b1;
                        if (wk_r == 4'(edoctl_pkg::WAKE_CYCLES - 1)) woken_nxt = 1'b1;
                    end
                    st_nxt = S_IDLE; cnt_nxt = c(edoctl_pkg::C_RP);
                end
            end
            S_SELF: if (cnt_r == '0 && !sleep) begin
                ras_nxt = 1'b1; cas_nxt = 1'b1; rdue_nxt = 1'b0; rcnt_nxt = '0;
                st_nxt = S_RPS; cnt_nxt = c(edoctl_pkg::C_RPS); // [R17]
            end
            S_RPS: if (cnt_r == '0) st_nxt = S_IDLE;
            default: st_nxt = S_IDLE;
        endcase
        // Row strobe low bound outside self refresh [R16]
        if (!ras_n && st_r != S_SELF && ras_cnt_r >= c(edoctl_pkg::C_RASMAX - 1)) begin
            ras_nxt = 1'b1; cas_nxt = 1'b1; we_nxt = 1'b1; oe_nxt = 1'b1;
            dqo_nxt = 1'b1; st_nxt = S_IDLE; cnt_nxt = c(edoctl_pkg::C_RP);
        end
        if (st_nxt == S_IDLE && cnt_nxt != '0) rdy_nxt = 1'b0;
    end
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            st_r <= S_WAKE; cnt_r <= c(WAKE_CYC); wk_r <= '0; woken_r <= 1'b0;
            rcnt_r <= '0; rdue_r <= 1'b0; ras_cnt_r <= '0;
            op_r <= edoctl_pkg::EDOCTL_OP_READ; a_r <= '0; wd_r <= '0; rd_r <= '0;
            ras_n <= 1'b1; cas_n <= 1'b1; we_n <= 1'b1; oe_n <= 1'b1;
            addr <= '0; dq_out <= '0; dq_oe_n <= 1'b1;
            rvalid <= 1'b0; rdata <= '0; ready <= 1'b0;
        end else begin
            st_r <= st_nxt; cnt_r <= cnt_nxt; wk_r <= wk_nxt; woken_r <= woken_nxt;
            rcnt_r <= rcnt_nxt; rdue_r <= rdue_nxt; ras_cnt_r <= ras_cnt_nxt;
            op_r <= op_nxt; a_r <= a_nxt; wd_r <= wd_nxt; rd_r <= rd_nxt;
            ras_n <= ras_nxt; cas_n <= cas_nxt; we_n <= we_nxt; oe_n <= oe_nxt;
            addr <= ad_nxt; dq_out <= wd_nxt; dq_oe_n <= dqo_nxt;
            rvalid <= rv_nxt; rdata <= rd_nxt; ready <= rdy_nxt;
        end
    end
    ////////////////////////////////////////////////////////////////
    a_cbr_we_high: assert property (@(posedge clk) disable iff (!rst_sync_n) // [R18]
        (!cas_n && $fell(ras_n)) |-> we_n ##1 we_n)
        else $error("write strobe low at refresh row fall");
    a_ras_max_low: assert property (@(posedge clk) disable iff (!rst_sync_n) // [R16]
        (st_r != S_SELF && !ras_n) |-> ras_cnt_r < c(edoctl_pkg::C_RASMAX))
        else $error("row strobe low too long");
    a_cas_high_ras: assert property (@(posedge clk) disable iff (!rst_sync_n) // [R8]
        ($fell(ras_n) && !cas_n) |-> $past(!cas_n, 1) && st_r == S_CHR)
        else $error("row fell with column low outside refresh");
    a_no_wake_acc: assert property (@(posedge clk) disable iff (!rst_sync_n) // [R1]
        (!woken_r) |-> !(st_r == S_RAS))
        else $error("access before wake-up done");
    a_od_before_drv: assert property (@(posedge clk) disable iff (!rst_sync_n) // [R11]
        $fell(dq_oe_n) && op_r == edoctl_pkg::EDOCTL_OP_RMW |-> $past(oe_n, 2))
        else $error("data driven before output disabled");
    a_early_we: assert property (@(posedge clk) disable iff (!rst_sync_n) // [R4]
        ($fell(cas_n) && op_r == edoctl_pkg::EDOCTL_OP_WRITE && !ras_n) |-> !we_n && oe_n)
        else $error("early write without write strobe low");
    a_rps_exit: assert property (@(posedge clk) disable iff (!rst_sync_n) // [R17]
        (st_r == S_SELF && st_nxt == S_RPS) |=> ras_n [*3])
        else $error("self refresh exit too short");
    a_up_round: assert property (@(posedge clk) disable iff (!rst_sync_n) // [R24]
        $rose(ras_n) && st_r == S_IDLE |-> $past(ras_cnt_r) + 1'b1 >= c(edoctl_pkg::C_RAS))
        else $error("row strobe pulse below minimum");
endmodule // edoctl_host

`default_nettype wire

// ==== hdl/edoctl_pkg.sv ====
// Timing constants and types for the EXTENDED_DATA_OUT_PAGE DRAM host controller
package edoctl_pkg;
    localparam int unsigned CLK_MHZ      = 40;
    // Minimum times in ns, rounded up to whole cycles
    localparam int unsigned T_RP_NS      = 30;
    localparam int unsigned T_RAS_NS     = 50;
    localparam int unsigned T_RCD_NS     = 11;
    localparam int unsigned T_CAS_NS     = 8;
    localparam int unsigned T_CP_NS      = 8;
    localparam int unsigned T_RAC_NS     = 50;
    localparam int unsigned T_CAC_NS     = 13;
    localparam int unsigned T_CSR_NS     = 5;
    localparam int unsigned T_CHR_NS     = 8;
    localparam int unsigned T_WRP_NS     = 8;
    localparam int unsigned T_RPS_NS     = 90;
    localparam int unsigned T_OD_NS      = 12;
    localparam int unsigned T_RWD_NS     = 67;
    localparam int unsigned T_WP_NS      = 5;
    // Long times
    localparam int unsigned T_WAKE_US    = 100;
    localparam int unsigned T_RASS_US    = 100;
    localparam int unsigned T_RAS_MAX_NS = 10000;
    localparam int unsigned T_REF_MS     = 64;
    localparam int unsigned ROWS         = 4096;
    localparam int unsigned WAKE_CYCLES  = 8;

    function automatic int unsigned cyc_up(input int unsigned ns);
        int unsigned c;
        c = (ns * CLK_MHZ + 999) / 1000;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int unsigned C_RP   = cyc_up(T_RP_NS);
    localparam int unsigned C_RAS  = cyc_up(T_RAS_NS);
    localparam int unsigned C_RCD  = cyc_up(T_RCD_NS);
    localparam int unsigned C_ACC  = cyc_up(T_RAC_NS) > cyc_up(T_CAC_NS) + C_RCD ?
                                     cyc_up(T_RAC_NS) - C_RCD : cyc_up(T_CAC_NS);
    localparam int unsigned C_CP   = cyc_up(T_CP_NS);
    localparam int unsigned C_CSR  = cyc_up(T_CSR_NS);
    localparam int unsigned C_CHR  = cyc_up(T_CHR_NS);
    localparam int unsigned C_WRP  = cyc_up(T_WRP_NS);
    localparam int unsigned C_RPS  = cyc_up(T_RPS_NS);
    localparam int unsigned C_OD   = cyc_up(T_OD_NS);
    localparam int unsigned C_RWD  = cyc_up(T_RWD_NS);
    localparam int unsigned C_WP   = cyc_up(T_WP_NS);
    localparam int unsigned C_RASMAX = T_RAS_MAX_NS * CLK_MHZ / 1000;
    // Defaults for long counts, overridable at the top
    localparam int unsigned C_WAKE = T_WAKE_US * CLK_MHZ;
    localparam int unsigned C_RASS = T_RASS_US * CLK_MHZ;
    localparam int unsigned C_RINT = T_REF_MS * 1000 * CLK_MHZ / ROWS;

    localparam int unsigned CNT_W  = 24;
    localparam int unsigned ADR_W  = 12;
    localparam int unsigned DQ_W   = 4;

    typedef enum logic [1:0] {EDOCTL_OP_READ, EDOCTL_OP_WRITE, EDOCTL_OP_RMW} edoctl_op_t;
endpackage

// ==== tb/edoctl_dram_model.sv ====
// Behavioural model of the EXTENDED_DATA_OUT_PAGE DRAM device facing the host controller
`timescale 1ns/1ps
`default_nettype none
module edoctl_dram_model (
    input  wire logic        ras_n,   // row strobe
    input  wire logic        cas_n,   // column strobe
    input  wire logic        we_n,    // write strobe
    input  wire logic        oe_n,    // output enable
    input  wire logic [11:0] addr,    // muxed address
    input  wire logic [3:0]  host_dq, // host drive value
    input  wire logic        dq_oe_n, // host drives when low
    output wire logic [3:0]  dq,      // resolved data pins
    output var  int          refr,    // refresh cycles seen
    output var  int          viol     // timing faults seen
);
    logic [3:0]  mem [int];
    logic [3:0]  q;
    logic [3:0]  last;
    logic        drv;
    logic [11:0] row;
    int          key;
    bit          col_before_row_refresh, sl, rd;
    realtime     t_rf, t_rr, t_cf;
    initial begin
        {refr, viol, drv, last, col_before_row_refresh, sl, rd} = '0;
        t_rr = 0.0;
        t_cf = 0.0;
    end
    ////////////////////////////////////////////////////////////////////////
    // Released pins show the flipped last value so a stale read never passes
    assign dq = !dq_oe_n ? host_dq : (drv ? q : ~last);
    always @(negedge drv) last = q;
    always @(posedge dq_oe_n) last = host_dq;
    always @(posedge drv or negedge dq_oe_n) if (drv && !dq_oe_n) viol++;
    always @(negedge ras_n) begin
        if (sl && $realtime - t_rr < 90.0) viol++;
        sl = 0;
        rd = 0;
        if (!cas_n) begin
            refr++;
            col_before_row_refresh = 1;
            if (!we_n || $realtime - t_cf < 5.0) viol++;
        end else begin
            row = addr;
            if (refr < 8) viol++;
        end
        t_rf = $realtime;
    end
    // Shortened self refresh: a column-first cycle held past 1 us counts as one
    always @(posedge ras_n) begin
        if (col_before_row_refresh && $realtime - t_rf > 1000.0) sl = 1;
        else if ($realtime - t_rf > 10000.0) viol++;
        col_before_row_refresh = 0;
        t_rr = $realtime;
        if (cas_n) drv <= #12 1'b0;
    end
    always @(posedge cas_n) begin
        if (col_before_row_refresh && $realtime - t_rf < 8.0) viol++;
        if (ras_n) drv <= #12 1'b0;
        else if (we_n === 1'b0) drv <= #12 1'b0;
    end
    always @(negedge cas_n) begin
        t_cf = $realtime;
        if (!ras_n && !col_before_row_refresh) begin
            key = int'({row, addr});
            if (!we_n) mem[key] = host_dq;
            else begin
                #((t_rf + 37.0 > t_cf) ? t_rf + 50.0 - $realtime : 13.0);
                q = mem.exists(key) ? mem[key] : 4'h0;
                rd = 1;
                if (!cas_n && we_n && !oe_n) drv = 1'b1;
            end
        end
    end
    always @(negedge we_n) if (!ras_n && !cas_n && !col_before_row_refresh) begin
        if (!oe_n) viol++;
        if ($realtime - t_rf < 67.0 || $realtime - t_cf < 28.0) viol++;
        #1 mem[key] = host_dq;
    end
    always @(posedge we_n) if (cas_n && !ras_n) drv <= #12 1'b0;
    always @(posedge oe_n) drv <= #12 1'b0;
    always @(negedge oe_n) if (!cas_n && !ras_n && rd) drv = 1'b1;
endmodule // edoctl_dram_model
`default_nettype wire

// ==== tb/edoctl_host_bench.sv ====
// Self-checking bench for the EXTENDED_DATA_OUT_PAGE DRAM host controller
`timescale 1ns/1ps
`default_nettype none
module edoctl_host_bench;
    localparam int WAKE = 50;
    logic                   clk = 1'b0, rst_n = 1'b0, req = 1'b0, sleep = 1'b0;
    edoctl_pkg::edoctl_op_t req_op = edoctl_pkg::EDOCTL_OP_READ;
    logic [23:0]            req_addr = 24'h000000;
    logic [3:0]             req_wdata = 4'h0, rdata, dq_in, dq_out, q;
    logic                   ready, rvalid, ras_n, cas_n, we_n, oe_n, dq_oe_n;
    logic [11:0]            addr;
    int                     refr, viol, r0, errors = 0, checks_done = 0;
    edoctl_host #(.WAKE_CYC(WAKE), .RASS_CYC(50), .RINT_CYC(400)) edoctl_host_inst (
        .clk(clk), .rst_n(rst_n), .req(req), .req_op(req_op), .req_addr(req_addr),
        .req_wdata(req_wdata), .sleep(sleep), .ready(ready), .rvalid(rvalid), .rdata(rdata),
        .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .oe_n(oe_n), .addr(addr),
        .dq_in(dq_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n));
    edoctl_dram_model edoctl_dram_model_inst (
        .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .oe_n(oe_n), .addr(addr),
        .host_dq(dq_out), .dq_oe_n(dq_oe_n), .dq(dq_in), .refr(refr), .viol(viol));
    initial forever #12.5 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_sim;
        if (errors == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Bounded wait at falling edges so the sample never races the launch edge
    task automatic wait_sig(input bit for_rvalid, input int lim);
        int n;
        n = 0;
        while ((for_rvalid ? rvalid : ready) !== 1'b1) begin
            @(negedge clk);
            n++;
            if (n > lim) begin
                chk("handshake timeout", 0, 1);
                end_sim();
            end
        end
    endtask
    task automatic access(input edoctl_pkg::edoctl_op_t op, input logic [23:0] a, input logic [3:0] d);
        @(negedge clk);
        req = 1'b1;
        req_op = op;
        req_addr = a;
        req_wdata = d;
        wait_sig(0, 5000);
        @(negedge clk);
        req = 1'b0;
        if (op != edoctl_pkg::EDOCTL_OP_WRITE) begin
            wait_sig(1, 100);
            q = rdata;
            @(negedge clk);
            chk("rvalid width", rvalid, 0);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_wake;
        int n;
        n = 0;
        while (ready !== 1'b1 && n < 5000) begin
            @(negedge clk);
            n++;
        end
        chk("wake timeout", n < 5000, 1);
        chk("pause before ready", n > WAKE, 1);
        chk("wake refreshes", refr >= 8, 1);
    endtask
    task automatic t_write_read;
        logic [23:0] a [3] = '{24'h000000, 24'hffffff, 24'h123456};
        logic [3:0]  d [3] = '{4'h5, 4'ha, 4'h3};
        foreach (a[i]) access(edoctl_pkg::EDOCTL_OP_WRITE, a[i], d[i]);
        foreach (a[i]) begin
            access(edoctl_pkg::EDOCTL_OP_READ, a[i], 4'h0);
            chk("read back", q, d[i]);
        end
    endtask
    task automatic t_rmw;
        access(edoctl_pkg::EDOCTL_OP_RMW, 24'h123456, 4'hc);
        chk("rmw old data", q, 4'h3);
        access(edoctl_pkg::EDOCTL_OP_RMW, 24'hffffff, 4'h6);
        chk("rmw old data 2", q, 4'ha);
        access(edoctl_pkg::EDOCTL_OP_READ, 24'h123456, 4'h0);
        chk("rmw new data", q, 4'hc);
    endtask
    task automatic t_refresh;
        r0 = refr;
        repeat (1000) @(negedge clk);
        chk("periodic refresh", refr - r0 >= 2, 1);
    endtask
    task automatic t_sleep;
        int n, bad, run;
        n = 0;
        bad = 0;
        run = 0;
        @(negedge clk);
        sleep = 1'b1;
        // A plain refresh holds both strobes low only briefly; wait past it
        while (run < 4 && n < 2000) begin
            @(negedge clk);
            n++;
            run = (ras_n === 1'b0 && cas_n === 1'b0) ? run + 1 : 0;
        end
        chk("self refresh entry", run, 4);
        repeat (100) begin
            @(negedge clk);
            if (ras_n !== 1'b0 || cas_n !== 1'b0 || ready !== 1'b0) bad++;
        end
        chk("self refresh hold", bad, 0);
        sleep = 1'b0;
        access(edoctl_pkg::EDOCTL_OP_READ, 24'hffffff, 4'h0);
        chk("data after sleep", q, 4'h6);
    endtask
    initial begin
        repeat (4) @(negedge clk);
        chk("ready in reset", ready, 0);
        chk("strobes idle", {ras_n, cas_n, we_n, oe_n, dq_oe_n}, 5'h1f);
        rst_n = 1'b1;
        t_wake();
        t_write_read();
        t_rmw();
        t_refresh();
        t_sleep();
        chk("device timing faults", viol, 0);
        end_sim();
    end
endmodule // edoctl_host_bench
`default_nettype wire
